/* afe_front_end_cfg.sv */
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "afe_cfg.svh"
module afe_front_end_cfg
(
	input  wire logic                clk_in,
	input  wire logic                rst_n_in,
	input  wire logic                ce_in,
	input  wire logic [3:0]          addr_in,
	input  wire logic [7:0]          wdata_in,
	input  wire logic                wr_in,
	input  wire logic                rd_in,
	output logic [7:0]               rdata_out,
	output afe_pkg::afe_gain_t       cur_gain_out,
	output afe_pkg::afe_gain_t       volt_gain_out,
	output afe_pkg::afe_range_t      cur_range_out,
	output logic                     cfg_valid_out,
	output logic signed [5:0]        cur_trim_steps_out,
	output logic signed [5:0]        volt_trim_steps_out,
	output logic signed [17:0]       cur_offset_uv_out,
	output logic signed [17:0]       volt_offset_uv_out,
	output logic                     integrator_en_out
);
	import afe_pkg::*;
	logic [7:0]  gain_r;
	logic [7:0]  gain_nxt;
	logic [7:0]  ctrim_r;
	logic [7:0]  ctrim_nxt;
	logic [7:0]  vtrim_r;
	logic [7:0]  vtrim_nxt;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;
	logic [2:0]  cg_code;
	logic [2:0]  vg_code;
	logic [1:0]  rg_code;
	logic        cg_ok;
	logic        vg_ok;
	logic        rg_ok;
	afe_trim_if  cur_t ();
	afe_trim_if  volt_t ();
	// ****************************************
	// Register file
	// ****************************************
	always_comb
	begin
		gain_nxt  = gain_r;
		ctrim_nxt = ctrim_r;
		vtrim_nxt = vtrim_r;
		rdata_nxt = 8'h00;
		if (wr_in)
		begin
			unique case (addr_in)
				`AFE_ADDR_GAIN:      gain_nxt  = wdata_in;
				`AFE_ADDR_CUR_TRIM:  ctrim_nxt = wdata_in;
				`AFE_ADDR_VOLT_TRIM: vtrim_nxt = wdata_in;
				default:             gain_nxt  = gain_r;
			endcase
		end
		if (rd_in)
		begin
			unique case (addr_in)
				`AFE_ADDR_GAIN:      rdata_nxt = gain_r;
				`AFE_ADDR_CUR_TRIM:  rdata_nxt = ctrim_r;
				`AFE_ADDR_VOLT_TRIM: rdata_nxt = vtrim_r;
				`AFE_ADDR_STATUS:    rdata_nxt = {4'h0, cur_t.valid, rg_ok, vg_ok, cg_ok};
				default:             rdata_nxt = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			gain_r  <= `AFE_GAIN_RST;
			ctrim_r <= `AFE_TRIM_RST;
			vtrim_r <= `AFE_TRIM_RST;
			rdata_r <= 8'h00;
		end
		else if (ce_in)
		begin
			gain_r  <= gain_nxt;
			ctrim_r <= ctrim_nxt;
			vtrim_r <= vtrim_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign rdata_out = rdata_r;
	// ****************************************
	// Field decode
	// ****************************************
	assign cg_code = gain_r[`AFE_CUR_GAIN_LSB +: 3];
	assign vg_code = gain_r[`AFE_VOLT_GAIN_LSB +: 3];
	assign rg_code = gain_r[`AFE_RANGE_LSB +: 2];
	assign cg_ok   = (cg_code <= 3'h4);
	assign vg_ok   = (vg_code <= 3'h4);
	assign rg_ok   = (rg_code != 2'h3);
	assign cur_gain_out  = cg_ok ? afe_gain_t'(cg_code) : AFE_G1;
	assign volt_gain_out = vg_ok ? afe_gain_t'(vg_code) : AFE_G1;
	assign cur_range_out = rg_ok ? afe_range_t'(rg_code) : AFE_FS_500MV;
	assign cfg_valid_out = cg_ok & vg_ok & rg_ok;
	assign integrator_en_out = ctrim_r[`AFE_INTEG_BIT];
	// ****************************************
	// Trim decoders
	// ****************************************
	assign cur_t.trim       = ctrim_r;
	assign cur_t.gain_code  = cg_code;
	assign volt_t.trim      = vtrim_r;
	assign volt_t.gain_code = vg_code;
	afe_trim_dec u_cur_dec
	(
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.t        (cur_t)
	);
	afe_trim_dec u_volt_dec
	(
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.t        (volt_t)
	);
	assign cur_trim_steps_out  = cur_t.steps;
	assign volt_trim_steps_out = volt_t.steps;
	assign cur_offset_uv_out   = cur_t.offset_uv;
	assign volt_offset_uv_out  = volt_t.offset_uv;
endmodule : afe_front_end_cfg

/* afe_cfg.svh */
`ifndef AFE_CFG_SVH
`define AFE_CFG_SVH
// ****************************************
// Register offsets
// ****************************************
`define AFE_ADDR_GAIN       4'h0
`define AFE_ADDR_CUR_TRIM   4'h1
`define AFE_ADDR_VOLT_TRIM  4'h2
`define AFE_ADDR_STATUS     4'h3
// ****************************************
// Field positions
// ****************************************
`define AFE_CUR_GAIN_LSB    0
`define AFE_RANGE_LSB       3
`define AFE_VOLT_GAIN_LSB   5
`define AFE_TRIM_SIGN_BIT   5
`define AFE_INTEG_BIT       7
// ****************************************
// Reset values
// ****************************************
`define AFE_GAIN_RST        8'h00
`define AFE_TRIM_RST        8'h00
// ****************************************
// Step weights in microvolts per gain
// ****************************************
`define AFE_STEP_UV_G1      11'd1610
`define AFE_STEP_UV_G2      11'd1190
`define AFE_STEP_UV_G4      11'd970
`define AFE_STEP_UV_G8      11'd840
`define AFE_STEP_UV_G16     11'd770
`endif

/* afe_pkg.sv */
package afe_pkg;
	typedef enum logic [2:0] {AFE_G1, AFE_G2, AFE_G4, AFE_G8, AFE_G16} afe_gain_t;
	typedef enum logic [1:0] {AFE_FS_500MV, AFE_FS_250MV, AFE_FS_125MV} afe_range_t;
endpackage : afe_pkg

/* afe_trim_if.sv */
`timescale 1ns/1ps
interface afe_trim_if;
	logic [7:0]  trim;
	logic [2:0]  gain_code;
	logic        valid;
	logic signed [5:0] steps;
	logic [10:0] step_uv;
	logic signed [17:0] offset_uv;
	modport ctrl (output trim, output gain_code, input valid, input steps, input step_uv,
		input offset_uv);
	modport dec (input trim, input gain_code, output valid, output steps, output step_uv,
		output offset_uv);
endinterface : afe_trim_if

/* afe_trim_dec.sv */
`timescale 1ns/1ps
`include "afe_cfg.svh"
module afe_trim_dec
(
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	input  wire logic  ce_in,
	afe_trim_if.dec    t
);
	import afe_pkg::*;
	logic [10:0]        step_nxt;
	logic signed [5:0]  steps_nxt;
	logic               valid_nxt;
	logic signed [17:0] off_nxt;
	logic [10:0]        step_r;
	logic signed [5:0]  steps_r;
	logic               valid_r;
	logic signed [17:0] off_r;
	// ****************************************
	// Sign-magnitude trim and gain weight
	// ****************************************
	always_comb
	begin
		valid_nxt = 1'b1;
		unique case (t.gain_code)
			3'h0: step_nxt = `AFE_STEP_UV_G1;
			3'h1: step_nxt = `AFE_STEP_UV_G2;
			3'h2: step_nxt = `AFE_STEP_UV_G4;
			3'h3: step_nxt = `AFE_STEP_UV_G8;
			3'h4: step_nxt = `AFE_STEP_UV_G16;
			default:
			begin
				step_nxt  = 11'h000;
				valid_nxt = 1'b0;
			end
		endcase
		if (t.trim[`AFE_TRIM_SIGN_BIT])
			steps_nxt = -$signed({1'b0, t.trim[4:0]});
		else
			steps_nxt = $signed({1'b0, t.trim[4:0]});
		off_nxt = 18'($signed(steps_nxt)) * $signed({7'h00, step_nxt});
	end
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			step_r  <= 11'h000;
			steps_r <= 6'h00;
			valid_r <= 1'b0;
			off_r   <= 18'h00000;
		end
		else if (ce_in)
		begin
			step_r  <= step_nxt;
			steps_r <= steps_nxt;
			valid_r <= valid_nxt;
			off_r   <= off_nxt;
		end
	end
	assign t.step_uv   = step_r;
	assign t.steps     = steps_r;
	assign t.valid     = valid_r;
	assign t.offset_uv = off_r;
endmodule : afe_trim_dec

/* afe_front_end_cfg_checker.sv */
`timescale 1ns/1ps
module afe_front_end_cfg_checker
(
	input wire logic                clk_in,
	input wire logic                rst_n_in,
	input wire logic                ce_in,
	input wire logic [3:0]          addr_in,
	input wire logic [7:0]          wdata_in,
	input wire logic                wr_in,
	input wire afe_pkg::afe_gain_t  cur_gain_out,
	input wire afe_pkg::afe_gain_t  volt_gain_out,
	input wire afe_pkg::afe_range_t cur_range_out,
	input wire logic                cfg_valid_out,
	input wire logic signed [5:0]   cur_trim_steps_out,
	input wire logic signed [5:0]   volt_trim_steps_out,
	input wire logic signed [17:0]  cur_offset_uv_out,
	input wire logic                integrator_en_out
);
	import afe_pkg::*;
	localparam int wt_uv [5] = '{1610, 1190, 970, 840, 770};
	logic              wg;
	logic              wc;
	logic              wv;
	logic signed [6:0] sm;
	assign wg = wr_in && ce_in && addr_in == 4'h0;
	assign wc = wr_in && ce_in && addr_in == 4'h1;
	assign wv = wr_in && ce_in && addr_in == 4'h2;
	assign sm = wdata_in[5] ? -$signed({2'h0, wdata_in[4:0]}) : $signed({2'h0, wdata_in[4:0]});
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	a_cur_gain: assert property (wg |=> cur_gain_out ==
		($past(wdata_in[2:0]) > 3'h4 ? 3'h0 : $past(wdata_in[2:0]))) else $error("cur gain");
	a_volt_gain: assert property (wg |=> volt_gain_out ==
		($past(wdata_in[7:5]) > 3'h4 ? 3'h0 : $past(wdata_in[7:5]))) else $error("volt gain");
	a_cur_range: assert property (wg |=> cur_range_out ==
		($past(wdata_in[4:3]) == 2'h3 ? 2'h0 : $past(wdata_in[4:3]))) else $error("range");
	a_reset_off: assert property ($rose(rst_n_in) |-> !integrator_en_out &&
		cur_gain_out == AFE_G1 && cur_trim_steps_out == 6'sh0) else $error("reset state");
	a_integ_bit: assert property (wc |=> integrator_en_out == $past(wdata_in[7]))
		else $error("integrator");
	a_cur_steps: assert property (wc |-> ##2 cur_trim_steps_out == $past(sm, 2))
		else $error("cur steps");
	a_volt_steps: assert property (wv |-> ##2 volt_trim_steps_out == $past(sm, 2))
		else $error("volt steps");
	a_offset_scale: assert property ($past(cfg_valid_out) |->
		cur_offset_uv_out == cur_trim_steps_out * wt_uv[$past(cur_gain_out)]) else $error("uv");
endmodule : afe_front_end_cfg_checker

/* afe_front_end_cfg_tb_top.sv */
`timescale 1ns/1ps
module afe_front_end_cfg_tb_top;
	import afe_pkg::*;
	logic clk_in, rst_n_in, ce_in, wr_in, rd_in, integ, cv;
	logic [3:0] addr_in;
	logic [7:0] wdata_in, rdata_out;
	afe_gain_t cg, vg;
	afe_range_t cr;
	logic signed [5:0] cs, vs;
	logic signed [17:0] co, vo;
	int n_mismatch = 0, check_count = 0;
	int wt [5] = '{1610, 1190, 970, 840, 770};
	afe_front_end_cfg dut_u (.clk_in, .rst_n_in, .ce_in, .addr_in, .wdata_in, .wr_in,
		.rd_in, .rdata_out, .cur_gain_out(cg), .volt_gain_out(vg), .cur_range_out(cr),
		.cfg_valid_out(cv), .cur_trim_steps_out(cs), .volt_trim_steps_out(vs),
		.cur_offset_uv_out(co), .volt_offset_uv_out(vo), .integrator_en_out(integ));
	initial
	begin
		clk_in = 0;
		forever #25 clk_in = ~clk_in;
	end
	task chk(input string nm, input logic signed [31:0] e, input logic signed [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk
	task bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= w;
		rd_in <= r;
		addr_in <= a;
		wdata_in <= d;
	endtask : bus
	task idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
		#1;
	endtask : idle
	task rd(input logic [3:0] a, input int e);
		bus(1'b0, 1'b1, a, 8'h00);
		idle(1);
		chk("rdata", e, rdata_out);
		idle(1);
		chk("rdata_idle", 0, rdata_out);
	endtask : rd
	function int sm(input logic [7:0] d);
		return d[5] ? -int'(d[4:0]) : int'(d[4:0]);
	endfunction : sm
	task t_reset;
		chk("integ", 0, integ);
		chk("cur_gain", 0, cg);
		rd(4'h1, 0);
		$display("test reset done");
	endtask : t_reset
	task t_gain;
		logic [7:0] d;
		for (int c = 0; c < 8; c++)
		begin
			d = {c[2:0], c[1:0], c[2:0]};
			bus(1'b1, 1'b0, 4'h0, d);
			idle(1);
			chk("cur_gain", c > 4 ? 0 : c, cg);
			chk("volt_gain", c > 4 ? 0 : c, vg);
			chk("range", c[1:0] == 3 ? 0 : c[1:0], cr);
			chk("cfg_valid", c <= 4 && c[1:0] != 3, cv);
			rd(4'h0, d);
			rd(4'h3, {4'h0, c <= 4, c[1:0] != 2'h3, c <= 4, c <= 4});
		end
		rd(4'hF, 0);
		bus(1'b1, 1'b0, 4'h3, 8'h00);
		rd(4'h0, 8'hFF);
		$display("test gain done");
	endtask : t_gain
	task t_trim;
		logic [7:0] ct, vt;
		for (int g = 0; g < 5; g++)
		begin
			ct = g[0] ? 8'hBF : 8'h25;
			vt = g[0] ? 8'h1F : 8'hE0;
			bus(1'b1, 1'b0, 4'h0, 8'(g * 33));
			bus(1'b1, 1'b0, 4'h1, ct);
			bus(1'b1, 1'b0, 4'h2, vt);
			idle(2);
			chk("cur_steps", sm(ct), cs);
			chk("volt_steps", sm(vt), vs);
			chk("cur_uv", sm(ct) * wt[g], co);
			chk("volt_uv", sm(vt) * wt[g], vo);
			chk("integ", ct[7], integ);
			rd(4'h1, ct);
		end
		$display("test trim done");
	endtask : t_trim
	task t_ce;
		@(posedge clk_in);
		ce_in <= 1'b0;
		bus(1'b1, 1'b0, 4'h0, 8'h22);
		idle(1);
		chk("cur_gain", 0, cg);
		chk("volt_gain", 0, vg);
		@(posedge clk_in);
		ce_in <= 1'b1;
		rd(4'h0, 8'hFF);
		$display("test clock enable done");
	endtask : t_ce
	task t_calib;
		bus(1'b1, 1'b0, 4'h1, 8'h00);
		bus(1'b1, 1'b0, 4'h1, 8'h27);
		bus(1'b1, 1'b0, 4'h2, 8'h07);
		idle(2);
		chk("integ", 0, integ);
		chk("cur_steps", -7, cs);
		chk("volt_steps", 7, vs);
		rd(4'h1, 8'h27);
		rd(4'h2, 8'h07);
		$display("test calib done");
	endtask : t_calib
	task t_rerun;
		bus(1'b1, 1'b0, 4'h1, 8'h80);
		idle(1);
		chk("integ", 1, integ);
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		idle(1);
		chk("integ", 0, integ);
		rd(4'h0, 0);
		$display("test rerun done");
	endtask : t_rerun
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	initial
	begin
		#100000;
		n_mismatch++;
		end_of_test;
	end
	initial
	begin
		rst_n_in = 0;
		{wr_in, rd_in, addr_in, wdata_in} = '0;
		ce_in = 1'b1;
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1;
		idle(1);
		t_reset;
		t_gain;
		t_ce;
		t_trim;
		t_calib;
		t_rerun;
		end_of_test;
	end
endmodule : afe_front_end_cfg_tb_top
bind afe_front_end_cfg afe_front_end_cfg_checker chk_u (.clk_in, .rst_n_in, .ce_in, .addr_in,
	.wdata_in, .wr_in, .cur_gain_out, .volt_gain_out, .cur_range_out, .cfg_valid_out,
	.cur_trim_steps_out, .volt_trim_steps_out, .cur_offset_uv_out, .integrator_en_out);
